// ==== verilog/fdcw_divider_ctrl.sv ====
// divider control word generation for the fractional-N synthesizer
`timescale 1ns/1ps
`default_nettype none
module fdcw_divider_ctrl
  import fdcw_pkg::*;
#(
  parameter longint unsigned REF_FREQ_HZ = REF_FREQ_HZ_DEF
)(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              fcWrEn,
  input  wire logic [SEL_W-1:0]  fcWrSel,
  input  wire logic [FC_W-1:0]   fcWrData,
  input  wire logic              rxCmd,
  input  wire logic [SEL_W-1:0]  rxFreqSel,
  input  wire logic              rxActive,
  input  wire logic              fractionDoubling,
  input  wire logic              outputDivideSelect,
  input  wire logic              divClkPin,
  output var  logic [P_W-1:0]    dividerControlWord,
  output var  logic [2:0]        outputDivideRatio,
  output var  logic [FC_W-1:0]   activeFreqWord
);
  // offset in normal-mode word units: 300 kHz over the fref/32768 step
  localparam longint unsigned OFFSET_BASE = (IF_OFFSET_HZ * FC_SCALE) / REF_FREQ_HZ;
  localparam logic [FC_W-1:0] OFF_NORM = OFFSET_BASE[FC_W-1:0];
  localparam logic [FC_W-1:0] OFF_DBL = OFF_NORM >> 1;
  localparam int IW = INT_W + 1;

  // frequency word bank
  logic [FC_W-1:0] fcBank_q [NUM_FC];
  logic [FC_W-1:0] fcBank_d [NUM_FC];

  // receive command selection
  logic [SEL_W-1:0] activeSel_q, activeSel_d;

  // divider clock pin synchroniser
  logic divSync1_q, divSync2_q, divSync3_q;
  logic pinLevel_q, pinLevel_d;
  logic tick;

  // divider word path
  logic [FC_W-1:0]      fcActive;
  logic [FC_W-1:0]      offsetWord;
  logic [FC_W-1:0]      sumNorm;
  logic [FRAC_W:0]      fracSumDbl;
  logic [IW-1:0]        integerPart;
  logic [FRAC_W-1:0]    fracField;
  logic [MOD_W-1:0]     modFrac;
  logic signed [SD_W-1:0] sdLevel;
  logic signed [9:0]    sdTerm;
  logic signed [9:0]    pWide;
  logic [P_W-1:0]       pWord_q, pWord_d;
  logic [2:0]           ratio_q, ratio_d;
  logic [FC_W-1:0]      fcOut_q, fcOut_d;

  // bank writes, one entry per select code
  always_comb
  begin
    for (int i = 0; i < NUM_FC; i++)
    begin
      fcBank_d[i] = fcBank_q[i];
      if (fcWrEn && (int'(fcWrSel) == i))
        fcBank_d[i] = fcWrData;
    end
  end

  // bank registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_FC; i++)
        fcBank_q[i] <= FC_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_FC; i++)
        fcBank_q[i] <= fcBank_d[i];
    end
  end

  // receive command picks the word that drives the divider
  always_comb
  begin
    activeSel_d = activeSel_q;
    if (rxCmd)
      activeSel_d = rxFreqSel;
  end

  // selection register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      activeSel_q <= SEL_RESET;
    else
      activeSel_q <= activeSel_d;
  end

  // three stage synchroniser on the divider output pin
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divSync1_q <= 1'b0;
      divSync2_q <= 1'b0;
      divSync3_q <= 1'b0;
      pinLevel_q <= 1'b0;
    end
    else
    begin
      divSync1_q <= divClkPin;
      divSync2_q <= divSync1_q;
      divSync3_q <= divSync2_q;
      pinLevel_q <= pinLevel_d;
    end
  end

  // a pin level counts once stages two and three agree
  always_comb
  begin
    pinLevel_d = pinLevel_q;
    if (divSync2_q == divSync3_q)
      pinLevel_d = divSync3_q;
  end

  // one tick per divider output cycle, on the first agreed high level
  assign tick = divSync2_q & divSync3_q & ~pinLevel_q;

  assign fcActive = fcBank_q[activeSel_q];

  // receive offset, scaled so it lands on the same frequency in every mode
  always_comb
  begin
    offsetWord = '0;
    if (rxActive)
    begin
      if (fractionDoubling)
        offsetWord = OFF_DBL << outputDivideSelect;
      else
        offsetWord = OFF_NORM << outputDivideSelect;
    end
  end

  // split into integer part and modulator fraction
  always_comb
  begin
    sumNorm = fcActive + offsetWord;
    fracSumDbl = {1'b0, fcActive[FRAC_W-1:0]} + offsetWord[FRAC_W:0];
    if (fractionDoubling)
    begin
      // a fraction overflow is worth two integer steps in this mode
      integerPart = {1'b0, fcActive[FC_W-1:FRAC_W]}
                    + {{(IW-2){1'b0}}, fracSumDbl[FRAC_W], 1'b0};
      fracField = fracSumDbl[FRAC_W-1:0];
    end
    else
    begin
      integerPart = {1'b0, sumNorm[FC_W-1:FRAC_W]};
      fracField = sumNorm[FRAC_W-1:0];
    end
    modFrac = {fracField, 1'b1};
  end

  fdcw_sd_mod #(
    .FW     (MOD_W)
  ) u_sd_mod (
    .clk    (clk),
    .rst_b  (rst_b),
    .step   (tick),
    .fracIn (modFrac),
    .sdOut  (sdLevel)
  );

  // adder: 64 + 2*(integer + modulator), modulator weight doubled on request
  always_comb
  begin
    if (fractionDoubling)
      sdTerm = 10'(sdLevel) <<< 2;
    else
      sdTerm = 10'(sdLevel) <<< 1;
    pWide = $signed({2'b00, DIV_BASE})
            + $signed({3'b000, integerPart, 1'b0})
            + sdTerm;
    pWord_d = pWord_q;
    if (tick)
      pWord_d = pWide[P_W-1:0];
    if (outputDivideSelect)
      ratio_d = RATIO_QUARTER;
    else
      ratio_d = RATIO_HALF;
    fcOut_d = fcActive;
  end

  // output registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pWord_q <= P_RESET;
      ratio_q <= RATIO_HALF;
      fcOut_q <= FC_RESET;
    end
    else
    begin
      pWord_q <= pWord_d;
      ratio_q <= ratio_d;
      fcOut_q <= fcOut_d;
    end
  end

  assign dividerControlWord = pWord_q;
  assign outputDivideRatio = ratio_q;
  assign activeFreqWord = fcOut_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_idle_cycle;
    !tick;
  endsequence

  sequence s_plain_tick;
    tick && !rxActive && !fractionDoubling;
  endsequence

  sequence s_double_tick;
    tick && !rxActive && fractionDoubling;
  endsequence

  property p_word_hold;
    s_idle_cycle |=> $stable(pWord_q);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed without tick");

  property p_normal_word;
    s_plain_tick |=> int'(pWord_q) == int'(DIV_BASE)
      + 2 * (int'($past(fcActive)) >> FRAC_W) + 2 * int'($past(sdLevel));
  endproperty
  a_normal_word: assert property (p_normal_word) else $error("normal word wrong");

  property p_double_word;
    s_double_tick |=> int'(pWord_q) == int'(DIV_BASE)
      + 2 * (int'($past(fcActive)) >> FRAC_W) + 4 * int'($past(sdLevel));
  endproperty
  a_double_word: assert property (p_double_word) else $error("doubling word wrong");

  property p_offset_norm;
    rxActive && !fractionDoubling |-> offsetWord == (OFF_NORM << outputDivideSelect);
  endproperty
  a_offset_norm: assert property (p_offset_norm) else $error("normal offset wrong");

  property p_offset_dbl;
    rxActive && fractionDoubling |-> offsetWord == (OFF_DBL << outputDivideSelect);
  endproperty
  a_offset_dbl: assert property (p_offset_dbl) else $error("doubling offset wrong");

  property p_frac_lsb;
    modFrac[0] && (modFrac[MOD_W-1:1] == fracField);
  endproperty
  a_frac_lsb: assert property (p_frac_lsb) else $error("appended one missing");

  property p_ratio;
    ##1 ratio_q == ($past(outputDivideSelect) ? RATIO_QUARTER : RATIO_HALF);
  endproperty
  a_ratio: assert property (p_ratio) else $error("output ratio wrong");

  property p_rx_select;
    rxCmd |=> activeSel_q == $past(rxFreqSel) ##1 fcOut_q == fcBank_q[$past(activeSel_q)];
  endproperty
  a_rx_select: assert property (p_rx_select) else $error("rx select not taken");

  sequence s_pin_rise;
    $rose(divSync3_q) && divSync2_q;
  endsequence

  property p_pin_tick;
    s_pin_rise |-> tick;
  endproperty
  a_pin_tick: assert property (p_pin_tick) else $error("pin edge gave no tick");

  property p_tick_single;
    tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick lasted too long");

  property p_word_range;
    int'(pWord_q) >= int'(DIV_BASE) - 4 && int'(pWord_q) <= int'(DIV_BASE) + 2 * 33 + 8;
  endproperty
  a_word_range: assert property (p_word_range) else $error("control word out of range");

  property p_no_offset;
    !rxActive |-> offsetWord == '0;
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("offset outside receive");

  property p_active_word;
    1'b1 |=> fcOut_q == $past(fcActive);
  endproperty
  a_active_word: assert property (p_active_word) else $error("active word copy wrong");

  property p_ratio_stable;
    $stable(outputDivideSelect) |=> $stable(ratio_q);
  endproperty
  a_ratio_stable: assert property (p_ratio_stable) else $error("ratio moved on its own");
endmodule
`default_nettype wire

// ==== verilog/fdcw_pkg.sv ====
// constants shared by the fractional-N divider control word logic
// Notes on behaviour
// - Integer part of the frequency word goes straight into the divider adder.
// - Fraction drives a sigma-delta modulator; outputs -1..+2, mean equals fraction.
// - A constant one is appended below the fraction, weight 1/65536.
// - Doubling bit set doubles the fractional contribution to the control word.
// - Normal divider ratio is 64 plus twice (2*word+1)/65536.
// - Output division one half or one quarter, chosen by divide select.
// - Doubling mode: bits 19:15 integer as is, bits 14:0 fraction times two.
// - Step size is fref/32768 times (1+doubling) over (1+divide select).
// - In receive mode the oscillator sits 300 kHz above the wanted centre.
// - Offset added before the adder, scaled to the active step size.
// - Four 20-bit frequency words; receive command selects the active one.
// - Receive offset ends 195 Hz below 300 kHz whatever the mode bits.
package fdcw_pkg;
  localparam int FC_W     = 20;
  localparam int INT_W    = 5;
  localparam int FRAC_W   = 15;
  localparam int MOD_W    = FRAC_W + 1;
  localparam int P_W      = 8;
  localparam int NUM_FC   = 4;
  localparam int SEL_W    = 2;
  localparam int SD_W     = 3;
  localparam int SD_MIN   = -1;
  localparam int SD_MAX   = 2;
  localparam logic [P_W-1:0] DIV_BASE = 8'h40;
  localparam logic [FC_W-1:0] FC_RESET = 20'h00000;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam logic [P_W-1:0] P_RESET = 8'h40;
  localparam logic [2:0] RATIO_HALF = 3'h2;
  localparam logic [2:0] RATIO_QUARTER = 3'h4;
  localparam longint unsigned IF_OFFSET_HZ = 300000;
  localparam longint unsigned FC_SCALE = 32768;
  localparam longint unsigned REF_FREQ_HZ_DEF = 16000000;
endpackage

// ==== verilog/fdcw_sd_mod.sv ====
// error feedback sigma-delta modulator with four output levels
`timescale 1ns/1ps
`default_nettype none
module fdcw_sd_mod
  import fdcw_pkg::*;
#(
  parameter int FW = MOD_W
)(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 step,
  input  wire logic [FW-1:0]        fracIn,
  output var  logic signed [SD_W-1:0] sdOut
);
  localparam int VW = FW + 6;
  localparam int QW = FW + 4;
  localparam logic signed [VW-1:0] Y_LO = VW'(SD_MIN);
  localparam logic signed [VW-1:0] Y_HI = VW'(SD_MAX);
  localparam logic signed [VW-1:0] Q_HI = VW'((1 <<< (QW - 1)) - 1);
  localparam logic signed [VW-1:0] Q_LO = VW'(-(1 <<< (QW - 1)));

  logic signed [QW-1:0]   q1_q, q2_q, q1_d, q2_d;
  logic signed [SD_W-1:0] sd_q, sd_d;
  logic signed [VW-1:0]   t1, t2, v, yRaw, yExt, qFull;

  // cascaded error taps shape the noise by (1 - z^-1)^2; the floor error
  // stays in (-1, 0], so v stays in (-1, 3) and the four levels never
  // overload, which keeps the long-run mean exact; a third tap would overload
  always_comb
  begin
    t1 = VW'(q1_q);
    t2 = VW'(q2_q);
    v = $signed({6'h00, fracIn}) - (t1 <<< 1) + t2;
    yRaw = v >>> FW;
    if (yRaw < Y_LO)
      yExt = Y_LO;
    else if (yRaw > Y_HI)
      yExt = Y_HI;
    else
      yExt = yRaw;
    qFull = (yExt <<< FW) - v;
    // saturate the error so a clamped output cannot run away
    if (qFull > Q_HI)
      qFull = Q_HI;
    else if (qFull < Q_LO)
      qFull = Q_LO;
    q1_d = q1_q;
    q2_d = q2_q;
    sd_d = sd_q;
    if (step)
    begin
      q1_d = qFull[QW-1:0];
      q2_d = q1_q;
      sd_d = yExt[SD_W-1:0];
    end
  end

  // modulator state registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q1_q <= '0;
      q2_q <= '0;
      sd_q <= '0;
    end
    else
    begin
      q1_q <= q1_d;
      q2_q <= q2_d;
      sd_q <= sd_d;
    end
  end

  assign sdOut = sd_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_sd_range;
    int'(sd_q) >= SD_MIN && int'(sd_q) <= SD_MAX;
  endproperty
  a_sd_range: assert property (p_sd_range) else $error("modulator output out of range");

  property p_sd_hold;
    !step |=> $stable(sd_q) && $stable(q1_q);
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("modulator moved without step");

  property p_no_clamp;
    yRaw >= Y_LO && yRaw <= Y_HI;
  endproperty
  a_no_clamp: assert property (p_no_clamp) else $error("quantiser overloaded");
endmodule
`default_nettype wire

// ==== tb/fdcw_div_model.sv ====
// behavioural divider output pin as seen from the control word block
`timescale 1ns/1ps
`default_nettype none
module fdcw_div_model #(
  parameter int FAST_CYC = 3,
  parameter int SLOW_CYC = 5
)(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  input  wire logic slow,
  output var  logic divClkPin
);
  int cnt_q;

  // pin stands low outside runs; each phase lasts FAST_CYC clocks, SLOW_CYC when slow
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 0;
      divClkPin <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 0;
      divClkPin <= #1 1'b0;
    end
    else if (cnt_q + 1 >= (slow ? SLOW_CYC : FAST_CYC))
    begin
      cnt_q <= 0;
      divClkPin <= #1 ~divClkPin;
    end
    else
    begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_fracn_divider_control_word.sv ====
// self-checking bench for the divider control word block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checksDone++; \
    if ((got) !== (ex)) \
    begin \
      nErrors++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tb_fracn_divider_control_word;
  import fdcw_pkg::*;
  localparam longint unsigned REF = 16000000;
  localparam int OFFS = int'(IF_OFFSET_HZ * FC_SCALE / REF);
  localparam int N = 1536;
  logic             clk;
  logic             rstB;
  logic             fcWrEn;
  logic [SEL_W-1:0] fcWrSel;
  logic [FC_W-1:0]  fcWrData;
  logic             rxCmd;
  logic [SEL_W-1:0] rxFreqSel;
  logic             rxActive;
  logic             fractionDoubling;
  logic             outputDivideSelect;
  logic             divClkPin;
  logic [P_W-1:0]   dividerControlWord;
  logic [2:0]       outputDivideRatio;
  logic [FC_W-1:0]  activeFreqWord;
  logic             run;
  logic             slow;
  int               nErrors;
  int               checksDone;

  fdcw_divider_ctrl #(.REF_FREQ_HZ(REF)) dut (
    .clk(clk), .rst_b(rstB), .fcWrEn(fcWrEn), .fcWrSel(fcWrSel), .fcWrData(fcWrData),
    .rxCmd(rxCmd), .rxFreqSel(rxFreqSel), .rxActive(rxActive),
    .fractionDoubling(fractionDoubling), .outputDivideSelect(outputDivideSelect),
    .divClkPin(divClkPin), .dividerControlWord(dividerControlWord),
    .outputDivideRatio(outputDivideRatio), .activeFreqWord(activeFreqWord)
  );
  fdcw_div_model pll (.clk(clk), .rst_b(rstB), .run(run), .slow(slow), .divClkPin(divClkPin));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [FC_W-1:0] bankVal(input int i);
    return FC_W'(20'h1C000 + i * 20'h01111);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic printVerdict;
    if (nErrors == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one mode setting: sample the word once per divider cycle and check range and mean
  task automatic runMean(input logic [FC_W-1:0] w, input logic dbl, ods, rx);
    logic [FC_W-1:0] e;
    logic [FRAC_W:0] s;
    int              o;
    int              intEff;
    int              mult;
    int              d;
    int              bad;
    longint          sumSd;
    longint          fEff;
    longint          err;
    o = rx ? (dbl ? (OFFS >> 1) << ods : OFFS << ods) : 0;
    e = w + FC_W'(o);
    s = {1'b0, w[FRAC_W-1:0]} + (FRAC_W+1)'(o);
    intEff = dbl ? int'(w[FC_W-1:FRAC_W]) + 2 * int'(s[FRAC_W]) : int'(e[FC_W-1:FRAC_W]);
    fEff = dbl ? longint'(s[FRAC_W-1:0]) : longint'(e[FRAC_W-1:0]);
    mult = dbl ? 4 : 2;
    bad = 0;
    sumSd = 0;
    fractionDoubling = dbl;
    outputDivideSelect = ods;
    rxActive = rx;
    fcWrEn = 1'b1;
    fcWrSel = 2'h3;
    fcWrData = w;
    rxCmd = 1'b1;
    rxFreqSel = 2'h3;
    cyc(1);
    fcWrEn = 1'b0;
    rxCmd = 1'b0;
    cyc(2);
    `CHK("activeFreqWord", w, activeFreqWord)
    `CHK("outputDivideRatio", ods ? RATIO_QUARTER : RATIO_HALF, outputDivideRatio)
    repeat (16) @(posedge divClkPin);
    repeat (N)
    begin
      @(posedge divClkPin);
      d = int'(dividerControlWord) - int'(DIV_BASE) - 2 * intEff;
      if (d % mult != 0 || d < -mult || d > 2 * mult)
        bad++;
      sumSd += d / mult;
    end
    err = sumSd * 65536 - N * (2 * fEff + 1);
    `CHK("sdRange", 0, bad)
    `CHK("sdMean", 1'b1, (err <= 6 * 65536 && err >= -6 * 65536))
  endtask

  // main sequence
  initial
  begin
    nErrors = 0;
    checksDone = 0;
    rstB = 1'b0;
    fcWrEn = 1'b0;
    fcWrSel = 2'h0;
    fcWrData = 20'h00000;
    rxCmd = 1'b0;
    rxFreqSel = 2'h0;
    rxActive = 1'b0;
    fractionDoubling = 1'b0;
    outputDivideSelect = 1'b0;
    run = 1'b0;
    slow = 1'b0;
    cyc(2);
    `CHK("resetWord", P_RESET, dividerControlWord)
    `CHK("resetRatio", RATIO_HALF, outputDivideRatio)
    `CHK("resetActive", FC_RESET, activeFreqWord)
    rstB = 1'b1;
    fcWrEn = 1'b1;
    for (int i = 0; i < NUM_FC; i++)
    begin
      fcWrSel = SEL_W'(i);
      fcWrData = bankVal(i);
      cyc(1);
    end
    fcWrEn = 1'b0;
    for (int k = NUM_FC - 1; k >= 0; k--)
    begin
      rxCmd = 1'b1;
      rxFreqSel = SEL_W'(k);
      cyc(1);
      rxCmd = 1'b0;
      cyc(2);
      `CHK("activeFreqWord", bankVal(k), activeFreqWord)
    end
    run = 1'b1;
    runMean(20'h1C000, 1'b0, 1'b0, 1'b0);
    runMean(20'h1C000, 1'b0, 1'b0, 1'b1);
    runMean(20'h1C000, 1'b0, 1'b1, 1'b1);
    runMean(20'h1C000, 1'b1, 1'b0, 1'b0);
    runMean(20'h1C000, 1'b1, 1'b1, 1'b1);
    slow = 1'b1;
    runMean(20'h2C000, 1'b1, 1'b0, 1'b1);
    printVerdict;
  end

  // watchdog against a hang
  initial
  begin
    #900000;
    nErrors++;
    printVerdict;
  end
endmodule
`default_nettype wire
